// file: inc/ioc_pkg.sv
// package of constants and types for the instantaneous overcurrent trip stage
//
// Contract
// R1 - general trip is OR of phase trips
// R2 - operation off, peak or fundamental, default off
// R3 - start current percent, 20 to 3000, default 200
// R4 - trip with no added delay above setting
// R5 - block input suppresses every trip
// R6 - double input doubles the start setting
// R7 - one trip output per phase, own decision
// R8 - on and off events, forwarded when configured
// R9 - trip states readable as online status
// R10 - peak mode drops at 0.85, fast timing
// R11 - fundamental mode drops at 0.85, slower timing
// R12 - source supplies fundamental rms per phase
// R13 - mode selects peak or rms for comparison
// R14 - off holds all trips low
`default_nettype none
package ioc_pkg;

  // ------------------------------------------------------------------
  // widths
  // ------------------------------------------------------------------
  localparam int IOC_CUR_W    = 16;
  localparam int IOC_SET_W    = 12;
  localparam int IOC_EFF_W    = 13;
  localparam int IOC_ADDR_W   = 8;
  localparam int IOC_NPH      = 3;

  // ------------------------------------------------------------------
  // register offsets (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] IOC_OFS_CTRL    = 8'h00;
  localparam logic [7:0] IOC_OFS_START   = 8'h04;
  localparam logic [7:0] IOC_OFS_ONLINE  = 8'h08;
  localparam logic [7:0] IOC_OFS_EVT_STS = 8'h0c;
  localparam logic [7:0] IOC_OFS_EVT_CLR = 8'h10;
  localparam logic [7:0] IOC_OFS_EVT_EN  = 8'h14;

  // ------------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------------
  localparam int IOC_CTRL_MODE_LSB = 0;
  localparam int IOC_CTRL_FWD_BIT  = 2;
  localparam int IOC_EVT_OFF_LSB   = 4;
  localparam logic [IOC_SET_W-1:0] IOC_START_MIN = 12'h0014;
  localparam logic [IOC_SET_W-1:0] IOC_START_MAX = 12'h0bb8;
  localparam logic [IOC_SET_W-1:0] IOC_START_RST = 12'h00c8;

  // reset ratio 0.85 as 17/20
  localparam logic [4:0] IOC_RATIO_NUM = 5'h11;
  localparam logic [4:0] IOC_RATIO_DEN = 5'h14;

  // ------------------------------------------------------------------
  // timing: limits only, the decision path takes one clock
  // ------------------------------------------------------------------
  localparam int IOC_CLK_MHZ        = 125;
  localparam int IOC_OP_PEAK_MS     = 15;
  localparam int IOC_RST_PEAK_MS    = 40;
  localparam int IOC_OP_FUND_MS     = 25;
  localparam int IOC_RST_FUND_MS    = 60;
  localparam int IOC_OP_PEAK_CYC    = IOC_OP_PEAK_MS * IOC_CLK_MHZ * 1000;
  localparam int IOC_RST_PEAK_CYC   = IOC_RST_PEAK_MS * IOC_CLK_MHZ * 1000;
  localparam int IOC_OP_FUND_CYC    = IOC_OP_FUND_MS * IOC_CLK_MHZ * 1000;
  localparam int IOC_RST_FUND_CYC   = IOC_RST_FUND_MS * IOC_CLK_MHZ * 1000;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    IOC_MODE_OFF,
    IOC_MODE_PEAK,
    IOC_MODE_FUND,
    IOC_MODE_RSVD
  } ioc_mode_type;

  typedef struct packed {
    logic [IOC_NPH-1:0][IOC_CUR_W-1:0] peak;
    logic [IOC_NPH-1:0][IOC_CUR_W-1:0] fund;
  } ioc_meas_type;

  typedef struct packed {
    logic [3:0] changed;
    logic [3:0] state;
  } ioc_event_type;

  typedef struct packed {
    logic [IOC_ADDR_W-1:0] addr;
    logic [31:0]           wdata;
    logic                  wr;
    logic                  rd;
  } ioc_bus_type;

endpackage : ioc_pkg
`default_nettype wire

// file: logic/ioc_trip.sv
// instantaneous overcurrent trip stage with register port and event interrupt
`default_nettype none
module ioc_trip (
  input  wire logic                     clk_sys,    // 125 MHz clock
  input  wire logic                     rstn,       // async reset, low active
  input  wire ioc_pkg::ioc_bus_type     bus,        // register port request
  output var  logic [31:0]              rdata,      // read data, cycle after rd
  input  wire ioc_pkg::ioc_meas_type    meas,       // peak and rms per phase
  input  wire logic                     meas_valid, // new measurement strobe
  input  wire logic                     block_in,   // disables the function
  input  wire logic                     double_setting_in, // doubles setting
  output var  logic                     phase1_trip,  // trip phase 1
  output var  logic                     phase2_trip,  // trip phase 2
  output var  logic                     phase3_trip,  // trip phase 3
  output var  logic                     general_trip, // any phase trip
  output var  logic                     evt_valid,  // forwarded event pulse
  output var  ioc_pkg::ioc_event_type   evt_data,   // forwarded event content
  output var  logic                     irq         // level interrupt
);
  import ioc_pkg::*;

  // ------------------------------------------------------------------
  // functions
  // ------------------------------------------------------------------

  // clamp a written start value into its legal range
  function automatic logic [IOC_SET_W-1:0] clamp_start(input logic [31:0] v);
    logic [IOC_SET_W-1:0] r;
    r = IOC_START_RST;
    if (v < 32'(IOC_START_MIN)) begin
      r = IOC_START_MIN;
    end else if (v > 32'(IOC_START_MAX)) begin
      r = IOC_START_MAX;
    end else begin
      r = v[IOC_SET_W-1:0];
    end
    return r;
  endfunction

  // per-phase decision with hysteresis: pick up above, drop below 0.85
  function automatic logic phase_decide(input logic                 held,
                                        input logic [IOC_CUR_W-1:0] cur,
                                        input logic [IOC_EFF_W-1:0] thr);
    logic [21:0] cur_scaled;
    logic [21:0] thr_scaled;
    logic        r;
    cur_scaled = 22'(cur) * 22'(IOC_RATIO_DEN);
    thr_scaled = 22'(thr) * 22'(IOC_RATIO_NUM);
    r = 1'b0;
    if (cur > 16'(thr)) begin
      r = 1'b1;
    end else if (held && (cur_scaled >= thr_scaled)) begin
      r = 1'b1;
    end
    return r;
  endfunction

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  ioc_mode_type          mode_q;
  ioc_mode_type          mode_d;
  logic                  fwd_q;
  logic                  fwd_d;
  logic [IOC_SET_W-1:0]  start_q;
  logic [IOC_SET_W-1:0]  start_d;
  logic [7:0]            evt_sts_q;
  logic [7:0]            evt_sts_d;
  logic [7:0]            evt_en_q;
  logic [7:0]            evt_en_d;
  logic [IOC_NPH-1:0]    trip_q;
  logic [IOC_NPH-1:0]    trip_d;
  logic                  gen_q;
  logic                  gen_d;
  logic [31:0]           rdata_q;
  logic [31:0]           rdata_d;
  logic                  evt_valid_q;
  logic                  evt_valid_d;
  ioc_event_type         evt_data_q;
  ioc_event_type         evt_data_d;
  logic                  irq_q;
  logic                  irq_d;

  // ------------------------------------------------------------------
  // register decode
  // ------------------------------------------------------------------
  wire logic sel_ctrl   = (bus.addr == IOC_OFS_CTRL);
  wire logic sel_start  = (bus.addr == IOC_OFS_START);
  wire logic sel_online = (bus.addr == IOC_OFS_ONLINE);
  wire logic sel_sts    = (bus.addr == IOC_OFS_EVT_STS);
  wire logic sel_clr    = (bus.addr == IOC_OFS_EVT_CLR);
  wire logic sel_en     = (bus.addr == IOC_OFS_EVT_EN);

  wire logic wr_ctrl  = bus.wr && sel_ctrl;
  wire logic wr_start = bus.wr && sel_start;
  wire logic wr_clr   = bus.wr && sel_clr;
  wire logic wr_en    = bus.wr && sel_en;

  // reserved mode code falls back to off, so a bad write cannot arm
  wire logic [1:0] mode_wr = bus.wdata[IOC_CTRL_MODE_LSB +: 2];
  wire ioc_mode_type mode_sel = (mode_wr == 2'(IOC_MODE_PEAK)) ? IOC_MODE_PEAK :
                                (mode_wr == 2'(IOC_MODE_FUND)) ? IOC_MODE_FUND :
                                IOC_MODE_OFF;

  // control and setting next values
  assign mode_d  = wr_ctrl ? mode_sel : mode_q; // R2
  assign fwd_d   = wr_ctrl ? bus.wdata[IOC_CTRL_FWD_BIT] : fwd_q;
  assign start_d = wr_start ? clamp_start(bus.wdata) : start_q; // R3
  assign evt_en_d = wr_en ? bus.wdata[7:0] : evt_en_q;

  // ------------------------------------------------------------------
  // decision path
  // ------------------------------------------------------------------

  // effective threshold, doubled on request
  wire logic [IOC_EFF_W-1:0] thr_eff = double_setting_in ? {start_q, 1'b0} // R6
                                                         : {1'b0, start_q};

  // off or block forces every trip low at once, whatever the currents
  wire logic func_on = (mode_q != IOC_MODE_OFF) && !block_in; // R5 R14

  // quantity selected by mode; rms comes from the front end
  wire logic use_peak = (mode_q == IOC_MODE_PEAK); // R13 R12

  logic [IOC_NPH-1:0] decide;

  // each phase looks only at its own current
  always_comb begin
    decide = trip_q;
    for (int p = 0; p < IOC_NPH; p++) begin
      if (!func_on) begin
        decide[p] = 1'b0; // R5 R14
      end else if (meas_valid) begin
        decide[p] = phase_decide(trip_q[p],  // R7 R10 R11
                                 use_peak ? meas.peak[p] : meas.fund[p], thr_eff);
      end
    end
  end

  // no delay stage: the trip follows the decision on the next edge
  assign trip_d = decide; // R4
  assign gen_d  = |decide; // R1

  // ------------------------------------------------------------------
  // events and interrupt
  // ------------------------------------------------------------------
  wire logic [3:0] state_now = {gen_d, trip_d};
  wire logic [3:0] state_old = {gen_q, trip_q};
  wire logic [3:0] chg       = state_now ^ state_old;
  wire logic [7:0] evt_set   = {chg & ~state_now, chg & state_now}; // R8
  wire logic [7:0] evt_clr   = wr_clr ? bus.wdata[7:0] : 8'h00;

  // a new event in the clear cycle survives
  assign evt_sts_d = (evt_sts_q & ~evt_clr) | evt_set; // R8

  // forward only when software enabled it
  assign evt_valid_d        = fwd_q && (chg != 4'h0); // R8
  assign evt_data_d         = '{changed: chg, state: state_now};

  assign irq_d = |(evt_sts_d & evt_en_d);

  // ------------------------------------------------------------------
  // read mux: unmapped and write-only read as zero
  // ------------------------------------------------------------------
  wire logic [31:0] rd_ctrl   = {29'h0, fwd_q, 2'(mode_q)};
  wire logic [31:0] rd_start  = {20'h0, start_q};
  wire logic [31:0] rd_online = {28'h0, gen_q, trip_q}; // R9
  wire logic [31:0] rd_sts    = {24'h0, evt_sts_q};
  wire logic [31:0] rd_en     = {24'h0, evt_en_q};

  assign rdata_d = !bus.rd   ? 32'h0000_0000 :
                   sel_ctrl   ? rd_ctrl :
                   sel_start  ? rd_start :
                   sel_online ? rd_online :
                   sel_sts    ? rd_sts :
                   sel_en     ? rd_en :
                   32'h0000_0000;

  // ------------------------------------------------------------------
  // state flops
  // ------------------------------------------------------------------

  // configuration
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      mode_q   <= IOC_MODE_OFF;
      fwd_q    <= 1'b0;
      start_q  <= IOC_START_RST;
      evt_en_q <= 8'h00;
    end else begin
      mode_q   <= mode_d;
      fwd_q    <= fwd_d;
      start_q  <= start_d;
      evt_en_q <= evt_en_d;
    end
  end

  // trips
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      trip_q <= '0;
      gen_q  <= 1'b0;
    end else begin
      trip_q <= trip_d;
      gen_q  <= gen_d;
    end
  end

  // events, interrupt and read data
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      evt_sts_q   <= 8'h00;
      evt_valid_q <= 1'b0;
      evt_data_q  <= '0;
      irq_q       <= 1'b0;
      rdata_q     <= 32'h0000_0000;
    end else begin
      evt_sts_q   <= evt_sts_d;
      evt_valid_q <= evt_valid_d;
      evt_data_q  <= evt_data_d;
      irq_q       <= irq_d;
      rdata_q     <= rdata_d;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign phase1_trip  = trip_q[0]; // R7
  assign phase2_trip  = trip_q[1];
  assign phase3_trip  = trip_q[2];
  assign general_trip = gen_q; // R1
  assign evt_valid    = evt_valid_q;
  assign evt_data     = evt_data_q;
  assign irq          = irq_q;
  assign rdata        = rdata_q;

endmodule // ioc_trip
`default_nettype wire

// file: verification/instantaneous_overcurrent_trip_test.sv
// self-checking bench of the overcurrent trip stage
`default_nettype none
module instantaneous_overcurrent_trip_test import ioc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic          clk_sys = 1'b0;
  logic          rstn = 1'b1;
  logic          go = 1'b0;
  logic          block_in = 1'b0;
  logic          dbl = 1'b0;
  ioc_bus_type   bus = '0;
  ioc_meas_type  cmd = '0;
  ioc_meas_type  meas;
  ioc_event_type evt_data;
  logic [31:0]   rdata, got;
  logic          meas_valid, p1, p2, p3, gen, evt_valid, irq;
  int            err_count = 0;
  int            compares = 0;
  wire [3:0]     trips = {gen, p3, p2, p1};

  always #4 clk_sys = ~clk_sys;

  ioc_front_model i_ioc_front_model (.clk_sys(clk_sys), .rstn(rstn), .go(go),
    .cmd(cmd), .meas_valid(meas_valid), .meas(meas));
  ioc_trip i_ioc_trip (.clk_sys(clk_sys), .rstn(rstn), .bus(bus), .rdata(rdata),
    .meas(meas), .meas_valid(meas_valid), .block_in(block_in),
    .double_setting_in(dbl), .phase1_trip(p1), .phase2_trip(p2), .phase3_trip(p3),
    .general_trip(gen), .evt_valid(evt_valid), .evt_data(evt_data), .irq(irq));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic ctrip(input logic [3:0] e);
    chk("trips", {28'h000_0000, e}, {28'h000_0000, trips});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus.wr <= 1'b0;
  endtask
  // read data is taken in the one cycle where it stands
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus.rd <= 1'b0;
    @(negedge clk_sys);
    got = rdata;
  endtask
  // one sample, phases packed as {phase3, phase2, phase1}
  task automatic samp(input logic [2:0][15:0] pk, input logic [2:0][15:0] fd);
    @(posedge clk_sys);
    cmd <= '{peak: pk, fund: fd};
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  task automatic t_reset;
    rd(IOC_OFS_CTRL);
    chk("ctrl reset", 32'h0000_0000, got);
    rd(8'h40);
    chk("unmapped read", 32'h0000_0000, got);
    samp({3{16'hffff}}, {3{16'hffff}});
    ctrip(4'h0);
    $display("test reset done");
  endtask
  task automatic t_start;
    logic [31:0] wv [4] = '{32'h0000_0005, 32'h0000_0fa0, 32'h0000_00c9, 32'h0000_00c8};
    logic [31:0] ev [4] = '{32'h0000_0014, 32'h0000_0bb8, 32'h0000_00c9, 32'h0000_00c8};
    rd(IOC_OFS_START);
    chk("start reset", 32'h0000_00c8, got);
    for (int i = 0; i < 4; i++) begin
      wr(IOC_OFS_START, wv[i]);
      rd(IOC_OFS_START);
      chk("start clamp", ev[i], got);
    end
    $display("test start done");
  endtask
  // peak mode with forwarding: strict pickup, hold at 0.85, events
  task automatic t_peak;
    wr(IOC_OFS_CTRL, 32'h0000_0005);
    wr(IOC_OFS_EVT_EN, 32'h0000_0001);
    samp({16'h0000, 16'h0000, 16'h00c8}, '0);
    ctrip(4'h0);
    samp({16'h0000, 16'h0000, 16'h00c9}, '0);
    ctrip(4'h9);
    chk("event", 32'h0000_0199, {23'h00_0000, evt_valid, evt_data});
    repeat (2) @(negedge clk_sys);
    chk("irq on", 32'h0000_0001, {31'h0000_0000, irq});
    rd(IOC_OFS_EVT_STS);
    chk("status", 32'h0000_0009, got);
    wr(IOC_OFS_EVT_CLR, 32'h0000_0001);
    rd(IOC_OFS_EVT_STS);
    chk("status clr", 32'h0000_0008, got);
    chk("irq off", 32'h0000_0000, {31'h0000_0000, irq});
    samp({16'h0000, 16'h00c9, 16'h00aa}, '0);
    ctrip(4'hb);
    chk("event", 32'h0000_012b, {23'h00_0000, evt_valid, evt_data});
    rd(IOC_OFS_ONLINE);
    chk("online", 32'h0000_000b, got);
    samp({16'h0000, 16'h0000, 16'h00a9}, '0);
    ctrip(4'h0);
    rd(IOC_OFS_EVT_STS);
    chk("status off", 32'h0000_00ba, got);
    $display("test peak done");
  endtask
  // fundamental mode ignores peaks; mode code 3 acts as off
  task automatic t_fund;
    wr(IOC_OFS_CTRL, 32'h0000_0002);
    samp({16'hffff, 16'h0000, 16'h0000}, '0);
    ctrip(4'h0);
    samp('0, {16'h00c9, 16'h0000, 16'h0000});
    ctrip(4'hc);
    chk("no forward", 32'h0000_0000, {31'h0000_0000, evt_valid});
    wr(IOC_OFS_CTRL, 32'h0000_0003);
    samp('0, {16'h00c9, 16'h0000, 16'h0000});
    ctrip(4'h0);
    $display("test fund done");
  endtask
  task automatic t_double_block;
    wr(IOC_OFS_CTRL, 32'h0000_0001);
    @(posedge clk_sys);
    dbl <= 1'b1;
    samp({16'h0000, 16'h0000, 16'h0190}, '0);
    ctrip(4'h0);
    samp({16'h0000, 16'h0000, 16'h0191}, '0);
    ctrip(4'h9);
    @(posedge clk_sys);
    block_in <= 1'b1;
    // block is taken at the edge after it rises, so look one cycle later
    repeat (2) @(negedge clk_sys);
    ctrip(4'h0);
    samp({16'h0000, 16'h0000, 16'h0191}, '0);
    ctrip(4'h0);
    @(posedge clk_sys);
    block_in <= 1'b0;
    $display("test double block done");
  endtask

  task automatic results;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // main sequence after five reset cycles
  initial begin
    // a real falling edge, so the async reset flops see it at time zero
    rstn <= 1'b0;
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    t_reset;
    t_start;
    t_peak;
    t_fund;
    t_double_block;
    results;
  end
  // watchdog, well beyond the fewer than a hundred cycles the tests need
  initial begin
    #100000;
    err_count++;
    results;
  end
endmodule // instantaneous_overcurrent_trip_test
`default_nettype wire

// file: verification/ioc_front_model.sv
// measurement front end model feeding peak and rms values per phase
`default_nettype none
module ioc_front_model (
  input  wire logic                  clk_sys,    // clock
  input  wire logic                  rstn,       // async reset, low active
  input  wire logic                  go,         // send one sample
  input  wire ioc_pkg::ioc_meas_type cmd,        // sample to send
  output var  logic                  meas_valid, // sample strobe
  output var  ioc_pkg::ioc_meas_type meas        // values to the stage
);
  import ioc_pkg::*;
  // between samples the values flip each cycle, so sampling without
  // the strobe shows up as wrong trips
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      meas_valid <= 1'b0;
      meas       <= '0;
    end else begin
      meas_valid <= go;
      meas       <= go ? cmd : ~meas;
    end
  end
endmodule // ioc_front_model
`default_nettype wire

// file: verification/ioc_trip_monitor.sv
// port checker of the overcurrent trip stage, bound to the top module
`default_nettype none
module ioc_trip_monitor (
  input wire logic                 clk_sys,      // clock
  input wire logic                 rstn,         // async reset, low active
  input wire ioc_pkg::ioc_bus_type bus,          // register request
  input wire logic [31:0]          rdata,        // read data
  input wire logic                 meas_valid,   // sample strobe
  input wire logic                 block_in,     // block input
  input wire logic                 phase1_trip,  // trip phase 1
  input wire logic                 phase2_trip,  // trip phase 2
  input wire logic                 phase3_trip,  // trip phase 3
  input wire logic                 general_trip, // any phase trip
  input wire logic                 evt_valid,    // event pulse
  input wire ioc_pkg::ioc_event_type evt_data    // event content
);
  import ioc_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // trip vector in the layout of the online and event words
  wire [3:0] trips = {general_trip, phase3_trip, phase2_trip, phase1_trip};

  property p_gen_or;
    general_trip == (phase1_trip | phase2_trip | phase3_trip);
  endproperty
  a_gen_or: assert property (p_gen_or) else $error("general trip not or of phases");
  property p_block;
    block_in |=> trips == 4'h0;
  endproperty
  a_block: assert property (p_block) else $error("trip while blocked");
  // a phase may only pick up on an accepted sample
  property p_rise;
    (|(trips[2:0] & ~$past(trips[2:0]))) |-> $past(meas_valid) && !$past(block_in);
  endproperty
  a_rise: assert property (p_rise) else $error("pickup without sample");
  // a mode write takes effect one cycle late, so two writes back count
  property p_fall;
    (|(~trips[2:0] & $past(trips[2:0]))) |->
      $past(meas_valid) || $past(block_in) || $past(bus.wr) || $past(bus.wr, 2);
  endproperty
  a_fall: assert property (p_fall) else $error("dropout without cause");
  property p_evt_state;
    evt_valid |-> evt_data.state == trips;
  endproperty
  a_evt_state: assert property (p_evt_state) else $error("event state wrong");
  property p_evt_chg;
    evt_valid |-> evt_data.changed == (trips ^ $past(trips)) && evt_data.changed != 4'h0;
  endproperty
  a_evt_chg: assert property (p_evt_chg) else $error("event change mask wrong");
  property p_online;
    bus.rd && bus.addr == IOC_OFS_ONLINE |=> rdata == {28'h000_0000, $past(trips)};
  endproperty
  a_online: assert property (p_online) else $error("online read wrong");
  property p_idle;
    !bus.rd |=> rdata == 32'h0000_0000;
  endproperty
  a_idle: assert property (p_idle) else $error("read data outside read slot");
  c_pickup: cover property ($rose(general_trip));
  c_event: cover property (evt_valid);
  c_block: cover property (block_in && general_trip);
endmodule // ioc_trip_monitor
bind ioc_trip ioc_trip_monitor i_ioc_trip_monitor (.clk_sys(clk_sys), .rstn(rstn),
  .bus(bus), .rdata(rdata), .meas_valid(meas_valid), .block_in(block_in),
  .phase1_trip(phase1_trip), .phase2_trip(phase2_trip), .phase3_trip(phase3_trip),
  .general_trip(general_trip), .evt_valid(evt_valid), .evt_data(evt_data));
`default_nettype wire
